// file: caption_slice_latch_irq_tb.sv
// Self-checking bench for the caption slice latch block
`timescale 1ns/1ps
module caption_slice_latch_irq_tb
	import csl_pkg::*;
;
	logic clock_i, sys_rst_i, psel, penable, pwrite, pready, pslverr, irq, pulse, vs, hs, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [4:0] rc;
	csl_line_s ln;
	int n_fail, checks_done, np, n0;
	csl_front fe(.clk_i(clock_i), .vsync_o(vs), .hsync_o(hs), .line_o(ln), .runin_o(rc));
	csl_top uut(.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .vsync_sep_i(vs),
		.hsync_sep_i(hs), .line_i(ln), .runin_count_i(rc), .irq_o(irq),
		.slice_irq_pulse_o(pulse));
	initial begin
		clock_i = 0;
		forever #12.5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) if (pulse === 1'b1) np <= np + 1;
	// ----
	// Bus, check and result tasks
	// ----
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %0t %h %h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i) penable <= 1;
		do @(posedge clock_i); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 32'h0);
		chk(r, e);
	endtask
	task automatic results();
		if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ----
	// Tests
	// ----
	initial begin
		#1000000;
		n_fail++;
		results();
	end
	initial begin
		{sys_rst_i, psel, penable, pwrite, paddr, pwdata} = {4'h8, 44'h0};
		repeat (20) @(posedge clock_i);
		sys_rst_i <= 0;
		for (int m = 0; m < 4; m++) begin
			wr(12'h000, {24'h0, m[1:0], 6'h0A});
			wr(12'h018, 32'h1);
			fe.field();
			n0 = np;
			fe.line(5'h0A, 16'hA5C3, 1);
			chk(np - n0, m == 1);
			fe.line(5'h15, 16'h3C5A, 1);
			chk(np - n0, 1);
			chk(irq, 1);
			rd(12'h008, m == 1 ? 32'hA5C3 : 32'h3C5A);
			rd(12'h00C, m[0] == m[1] ? 32'hA5C3 : 32'h0);
			rd(12'h004, 32'h1);
			rd(12'h000, {24'h0, m[1:0], m[0] == m[1], 5'h0A});
			rd(12'h010, 32'hA8);
			rd(12'h014, 32'h1);
			wr(12'h01C, 32'h1);
			rd(12'h014, 32'h0);
			chk(irq, 0);
		end
		fe.field();
		rd(12'h008, 32'h0);
		rd(12'h00C, 32'h0);
		rd(12'h004, 32'h0);
		n0 = np;
		fe.line(5'h15, 16'h1234, 0);
		chk(np - n0, 0);
		wr(12'h018, 32'h0);
		fe.line(5'h15, 16'h1234, 1);
		rd(12'h014, 32'h1);
		chk(irq, 0);
		wr(12'h018, 32'h1);
		rd(12'h014, 32'h1);
		chk(irq, 1);
		apb(0, 12'h020, 32'h0);
		chk(err, 1);
		results();
	end
endmodule
bind csl_top csl_sva u_sva(.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .line_i(line_i),
	.irq_o(irq_o), .slice_irq_pulse_o(slice_irq_pulse_o));

// file: csl_cfg.svh
// Register offsets, field positions, reset values and counts of the caption slice latch block
`ifndef CSL_CFG_SVH
`define CSL_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CSL_OFF_LINE_SEL 12'h000
`define CSL_OFF_CTRL_TWO 12'h004
`define CSL_OFF_DATA_ONE 12'h008
`define CSL_OFF_DATA_TWO 12'h00C
`define CSL_OFF_RUNIN 12'h010
`define CSL_OFF_IRQ_STAT 12'h014
`define CSL_OFF_IRQ_EN 12'h018
`define CSL_OFF_IRQ_CLR 12'h01C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSL_LS_MODE_HI 7
`define CSL_LS_MODE_LO 6
`define CSL_LS_FLAG2 5
`define CSL_CT2_FLAG1 0
`define CSL_RUNIN_LSB 3

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define CSL_LINE_SEL_RST 8'h00
`define CSL_FIXED_LINE 5'h15
`define CSL_IRQ_EN_RST 1'h0

`endif

// file: csl_front.sv
// Behavioural slicing front end: field sync, line sync and sliced lines
`timescale 1ns/1ps
module csl_front
	import csl_pkg::*;
(
	input wire logic clk_i,
	output logic vsync_o,
	output logic hsync_o,
	output csl_line_s line_o,
	output logic [4:0] runin_o
);
	int cnt = 0;
	initial begin
		vsync_o = 0;
		hsync_o = 0;
		line_o = '0;
		runin_o = 5'h1F;
	end
	task automatic field();
		@(posedge clk_i) vsync_o <= 1;
		repeat (4) @(posedge clk_i);
		vsync_o <= 0;
		repeat (6) @(posedge clk_i);
		cnt = 0;
	endtask
	// Pulses hsync up to the wanted line, then hands over 16 bits
	task automatic line(input logic [4:0] n, input logic [15:0] d, input logic ok);
		while (cnt < n) begin
			hsync_o <= 1;
			repeat (4) @(posedge clk_i);
			hsync_o <= 0;
			repeat (4) @(posedge clk_i);
			cnt++;
		end
		repeat (4) @(posedge clk_i);
		line_o <= '{1'b1, ok, d};
		runin_o <= n;
		@(posedge clk_i);
		// Outside the pulse the data lines never hold the last word
		line_o <= '{1'b0, 1'b0, ~d};
		runin_o <= ~n;
		repeat (4) @(posedge clk_i);
	endtask
endmodule

// file: csl_pkg.sv
// Types shared by the caption slice latch block
package csl_pkg;

	// One sliced line handed over by the slicing front end
	typedef struct packed {
		logic done;
		logic runin_ok;
		logic [15:0] data;
	} csl_line_s;

	// APB request fields
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} csl_apb_req_s;

	typedef enum logic [1:0] {
		CSL_IDLE,
		CSL_ACCESS
	} csl_bus_e;

	typedef struct packed {
		csl_bus_e bus;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [1:0] vsync_sync;
		logic [1:0] hsync_sync;
		logic vsync_prev;
		logic hsync_prev;
		logic [4:0] line_cnt;
		logic [7:0] line_sel;
		logic flag1;
		logic [15:0] data_one;
		logic [15:0] data_two;
		logic [4:0] runin;
		logic irq_stat;
		logic irq_en;
		logic irq_o;
		logic pulse_o;
	} csl_state_s;

endpackage

// file: csl_sva.sv
// Port-level assertions for the caption slice latch block
`timescale 1ns/1ps
module csl_sva
	import csl_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Watched ports
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire csl_line_s line_i,
	input wire logic irq_o,
	input wire logic slice_irq_pulse_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	property p_pulse; slice_irq_pulse_o |=> !slice_irq_pulse_o; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse too long");
	property p_cause; slice_irq_pulse_o |-> $past(line_i.done && line_i.runin_ok); endproperty
	a_cause: assert property (p_cause) else $error("pulse without line");
	// Enable writes may also raise the level, in the same cycle as the bus answer
	property p_lvl; $rose(irq_o) |-> slice_irq_pulse_o || pready_o || $past(pready_o); endproperty
	a_lvl: assert property (p_lvl) else $error("irq without cause");
	property p_rdy; pready_o |-> $past(psel_i && penable_i); endproperty
	a_rdy: assert property (p_rdy) else $error("ready without access");
	property p_one; pready_o |=> !pready_o; endproperty
	a_one: assert property (p_one) else $error("ready too long");
	property p_err; pslverr_o |-> pready_o; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_ans; psel_i && penable_i |-> ##[0:3] pready_o; endproperty
	a_ans: assert property (p_ans) else $error("no bus answer");
	property p_rst; $fell(sys_rst_i) |-> !irq_o && !pready_o && !slice_irq_pulse_o; endproperty
	a_rst: assert property (p_rst) else $error("outputs set after reset");
endmodule

// file: csl_top.sv
// Caption slice result latch, line counter and slicer interrupt with APB registers
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "csl_cfg.svh"

module csl_top
	import csl_pkg::*;
(
	// Clock, reset, enable
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Slicing front end
	input wire logic vsync_sep_i,
	input wire logic hsync_sep_i,
	input wire csl_line_s line_i,
	input wire logic [4:0] runin_count_i,
	// Interrupts
	output logic irq_o,
	output logic slice_irq_pulse_o
);

	csl_state_s r;
	csl_state_s next_r;

	// ----------------------------------------
	// Combinational next state
	// ----------------------------------------
	always_comb begin
		// Edge and match terms
		logic vs_fall;
		logic hs_rise;
		logic [1:0] mode;
		logic is_fixed;
		logic is_prog;
		logic got_line;
		logic slot_one;
		logic slot_two;
		logic fire;
		// Bus strobes
		logic wr;
		logic rd;

		// Every temporary gets a value first
		vs_fall = 1'b0;
		hs_rise = 1'b0;
		mode = 2'h0;
		is_fixed = 1'b0;
		is_prog = 1'b0;
		got_line = 1'b0;
		slot_one = 1'b0;
		slot_two = 1'b0;
		fire = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		next_r = r;

		// ----------------------------------------
		// Sync pins and edge detection
		// ----------------------------------------
		// Sync pins pass two flip-flops; only the second stage is read
		next_r.vsync_sync[0] = vsync_sep_i;
		next_r.vsync_sync[1] = r.vsync_sync[0];
		next_r.hsync_sync[0] = hsync_sep_i;
		next_r.hsync_sync[1] = r.hsync_sync[0];
		next_r.vsync_prev = r.vsync_sync[1];
		next_r.hsync_prev = r.hsync_sync[1];
		// Edge stages reset low, the idle level of both pins, so no edge follows reset
		// A falling vsync starts a field
		vs_fall = r.vsync_prev & ~r.vsync_sync[1];
		// A rising hsync counts one line
		hs_rise = ~r.hsync_prev & r.hsync_sync[1];

		// ----------------------------------------
		// Line counter
		// ----------------------------------------
		// Counter wraps past 31; a wrapped count may match the programmed line again
		if (vs_fall) begin
			next_r.line_cnt = 5'h00;
		end else if (hs_rise) begin
			next_r.line_cnt = r.line_cnt + 5'h01;
		end

		// ----------------------------------------
		// Line match and slot routing
		// ----------------------------------------
		mode = {r.line_sel[`CSL_LS_MODE_HI], r.line_sel[`CSL_LS_MODE_LO]};
		// Line 21 is a fixed count after field start
		is_fixed = (r.line_cnt == `CSL_FIXED_LINE);
		is_prog = (r.line_cnt == r.line_sel[4:0]);
		got_line = line_i.done & line_i.runin_ok;

		// Route each sliced line to its slot by mode
		// A programmed line equal to 21 goes to slot one only
		case (mode)
			2'b00: begin
				slot_one = is_fixed;
				slot_two = is_prog & ~is_fixed;
				fire = is_fixed;
			end
			2'b01: begin
				slot_one = is_prog;
				slot_two = 1'b0;
				fire = is_prog;
			end
			2'b10: begin
				slot_one = is_fixed;
				slot_two = 1'b0;
				fire = is_fixed;
			end
			2'b11: begin
				slot_one = is_fixed;
				slot_two = is_prog & ~is_fixed;
				fire = is_fixed;
			end
			default: begin
				slot_one = 1'b0;
				slot_two = 1'b0;
				fire = 1'b0;
			end
		endcase

		// ----------------------------------------
		// Result capture and field clear
		// ----------------------------------------
		// Pulse stands one cycle: it drops unless an event sets it below
		next_r.pulse_o = 1'b0;
		if (got_line) begin
			// Run-in count follows every confirmed line; only valid once the interrupt is seen
			next_r.runin = runin_count_i;
			if (slot_one) begin
				next_r.data_one = line_i.data;
				next_r.flag1 = 1'b1;
			end
			if (slot_two) begin
				next_r.data_two = line_i.data;
				next_r.line_sel[`CSL_LS_FLAG2] = 1'b1;
			end
		end
		// Field start wins over a line landing in the same cycle
		if (vs_fall) begin
			next_r.flag1 = 1'b0;
			next_r.line_sel[`CSL_LS_FLAG2] = 1'b0;
			next_r.data_one = 16'h0000;
			next_r.data_two = 16'h0000;
		end

		// ----------------------------------------
		// APB slave, one wait state
		// ----------------------------------------
		// Ready comes one cycle into the access phase and stands one cycle; the state
		// then idles one cycle, and a setup that follows at once still stands then
		next_r.pready = 1'b0;
		// Error stands only together with ready
		next_r.pslverr = 1'b0;
		case (r.bus)
			CSL_IDLE: begin
				if (psel_i & ~penable_i) begin
					next_r.bus = CSL_ACCESS;
				end else begin
					next_r.bus = CSL_IDLE;
				end
			end
			CSL_ACCESS: begin
				if (psel_i & penable_i & ~r.pready) begin
					next_r.pready = 1'b1;
					wr = pwrite_i;
					rd = ~pwrite_i;
				end else if (r.pready) begin
					next_r.bus = CSL_IDLE;
				end else begin
					next_r.bus = CSL_ACCESS;
				end
			end
			default: begin
				next_r.bus = CSL_IDLE;
			end
		endcase

		// ----------------------------------------
		// Register read
		// ----------------------------------------
		if (rd) begin
			next_r.prdata = 32'h0000_0000;
			case (paddr_i)
				// Mode, flag 2 and line number
				`CSL_OFF_LINE_SEL: begin
					next_r.prdata[7:0] = r.line_sel;
				end
				// Flag 1 alone
				`CSL_OFF_CTRL_TWO: begin
					next_r.prdata[`CSL_CT2_FLAG1] = r.flag1;
				end
				// Caption words in the low half
				`CSL_OFF_DATA_ONE: begin
					next_r.prdata[15:0] = r.data_one;
				end
				`CSL_OFF_DATA_TWO: begin
					next_r.prdata[15:0] = r.data_two;
				end
				// Run-in count sits above three unused bits
				`CSL_OFF_RUNIN: begin
					next_r.prdata[`CSL_RUNIN_LSB +: 5] = r.runin;
				end
				// Sticky status, enable and a clear word that reads zero
				`CSL_OFF_IRQ_STAT: begin
					next_r.prdata[0] = r.irq_stat;
				end
				`CSL_OFF_IRQ_EN: begin
					next_r.prdata[0] = r.irq_en;
				end
				`CSL_OFF_IRQ_CLR: begin
					next_r.prdata[0] = 1'b0;
				end
				default: begin
					next_r.pslverr = 1'b1;
				end
			endcase
		end

		// ----------------------------------------
		// Register write
		// ----------------------------------------
		if (wr) begin
			case (paddr_i)
				// Flag 2 is hardware-owned, software writes only mode and line
				`CSL_OFF_LINE_SEL: begin
					next_r.line_sel[7:6] = pwdata_i[7:6];
					next_r.line_sel[4:0] = pwdata_i[4:0];
				end
				`CSL_OFF_IRQ_EN: begin
					next_r.irq_en = pwdata_i[0];
				end
				// Write one to clear the status
				`CSL_OFF_IRQ_CLR: begin
					if (pwdata_i[0]) begin
						next_r.irq_stat = 1'b0;
					end
				end
				// Read-only words take a write without effect and without error
				`CSL_OFF_CTRL_TWO: begin
					next_r.pslverr = 1'b0;
				end
				`CSL_OFF_DATA_ONE: begin
					next_r.pslverr = 1'b0;
				end
				`CSL_OFF_DATA_TWO: begin
					next_r.pslverr = 1'b0;
				end
				`CSL_OFF_RUNIN: begin
					next_r.pslverr = 1'b0;
				end
				`CSL_OFF_IRQ_STAT: begin
					next_r.pslverr = 1'b0;
				end
				default: begin
					next_r.pslverr = 1'b1;
				end
			endcase
		end

		// ----------------------------------------
		// Slicer interrupt
		// ----------------------------------------
		// Event after the clear write so the set beats a same-cycle clear
		if (got_line & fire) begin
			next_r.pulse_o = 1'b1;
			next_r.irq_stat = 1'b1;
		end
		// Level follows the next status and enable, so it moves on the same edge
		next_r.irq_o = next_r.irq_stat & next_r.irq_en;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Clock enable low freezes every field, bus handshake included
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			// Bus side
			r.bus <= CSL_IDLE;
			r.pready <= 1'b0;
			r.pslverr <= 1'b0;
			r.prdata <= 32'h0000_0000;
			// Sync stages and line counter
			r.vsync_sync <= 2'h0;
			r.hsync_sync <= 2'h0;
			r.vsync_prev <= 1'b0;
			r.hsync_prev <= 1'b0;
			r.line_cnt <= 5'h00;
			// Registers and results
			r.line_sel <= `CSL_LINE_SEL_RST;
			r.flag1 <= 1'b0;
			r.data_one <= 16'h0000;
			r.data_two <= 16'h0000;
			r.runin <= 5'h00;
			// Interrupt
			r.irq_stat <= 1'b0;
			r.irq_en <= `CSL_IRQ_EN_RST;
			r.irq_o <= 1'b0;
			r.pulse_o <= 1'b0;
		end else if (clk_en_i) begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// Output ports
	// ----------------------------------------
	// All outputs come straight from the state flip-flops
	assign prdata_o = r.prdata;
	assign pready_o = r.pready;
	assign pslverr_o = r.pslverr;
	assign irq_o = r.irq_o;
	assign slice_irq_pulse_o = r.pulse_o;

endmodule
